/* File: command_touch_readout.sv */
`timescale 1ns/1ps
// i2c slave touch readout: interrupt on pressure, one conversion per accepted read address
module command_touch_readout
  import touch_pkg::*;
#(
  parameter int DATA_W = RESULT_BITS
)
(
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  // panel side
  input  wire logic              pen_down_i,
  output logic                   x_drv_o,
  output logic                   y_drv_o,
  output logic                   z_drv_o,
  // converter
  output logic                   conv_start_o,
  input  wire logic              conv_done_i,
  input  wire logic [DATA_W-1:0] conv_data_i,
  // host side
  output logic                   pen_touch_irq_n,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o
);
  // refuse result widths that the 16-bit result shifter cannot carry
  if (DATA_W < 1 || DATA_W > 16)
  begin : g_width_check
    $error("DATA_W must be 1..16");
  end

  typedef enum {ST_IDLE, ST_ADDR, ST_ACK, ST_CMD, ST_RDATA, ST_RACK, ST_IGNORE} bus_st_t;

  logic scl_s, sda_s, pen_s;      // synchronised pins
  logic scl_d_r, sda_d_r;         // previous samples
  bus_st_t st_r;                  // bus state
  logic [7:0]  sh_r;              // receive shifter
  logic [3:0]  bit_r;             // bit counter
  logic        rd_r;              // read direction
  logic [15:0] tx_r;              // result word, msb first
  logic        drv_on_r;          // a layer driver is energised
  logic [1:0]  sel_r;             // selected coordinate
  logic        conv_pend_r;       // conversion running

  sync_2ff u_scl (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .async_i(scl_i), .sync_o(scl_s));
  sync_2ff u_sda (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .async_i(sda_i), .sync_o(sda_s));
  // pressure sense idles low, so its synchroniser resets low: no false interrupt
  sync_2ff #(.RST_VAL(1'b0)) u_pen (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
                                    .async_i(pen_down_i), .sync_o(pen_s));

  // bus event decode
  wire scl_rise  = scl_s & ~scl_d_r;
  wire scl_fall  = ~scl_s & scl_d_r;
  wire start_ev  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_ev   = scl_s & scl_d_r & ~sda_d_r & sda_s;
  // address sits in the upper seven bits, direction in bit 0
  wire addr_hit  = (sh_r[7:1] == DEV_ADDR);
  wire [1:0] cmd_sel = sh_r[CMD_SEL_HI:CMD_SEL_LO];
  // result left-justified in the 16-bit shifter
  wire [15:0] tx_load = 16'(conv_data_i) << (16 - DATA_W);
  // read address accepted: start converting a whole bit ahead of the first data bit
  wire rd_go     = (st_r == ST_ADDR) & (bit_r == 4'h8) & scl_fall & addr_hit & sh_r[0];
  // device answers while pressure is present or while a layer driver is still on
  wire talk_ok   = pen_s | drv_on_r;                                  // [R15]

  // edge history
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // interrupt follows pressure; low while idle and pressed
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pen_touch_irq_n <= 1'b1;
    else
      pen_touch_irq_n <= ~(pen_s & ~drv_on_r);                        // [R2]
  end

  // slave state machine
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_r      <= ST_IDLE;
      sh_r      <= 8'h00;
      bit_r     <= 4'h0;
      rd_r      <= 1'b0;
    end
    else if (stop_ev)
      st_r <= ST_IDLE;
    else if (start_ev)
    begin
      // start or repeated start restarts framing
      st_r  <= talk_ok ? ST_ADDR : ST_IGNORE;                         // [R15] [R11]
      bit_r <= 4'h0;
    end
    else if (scl_rise && (st_r == ST_ADDR || st_r == ST_CMD))
    begin
      sh_r  <= {sh_r[6:0], sda_s};
      bit_r <= bit_r + 4'h1;
    end
    else if (scl_fall)
    begin
      case (st_r)
        ST_ADDR:
        begin
          if (bit_r == 4'h8)
          begin
            if (addr_hit)
            begin
              rd_r  <= sh_r[0];
              st_r  <= ST_ACK;
            end
            else
              st_r <= ST_IGNORE;
          end
        end
        ST_CMD:
        begin
          if (bit_r == 4'h8)
            st_r <= ST_ACK;
        end
        ST_ACK:
        begin
          bit_r <= 4'h0;
          if (rd_r)
            st_r <= ST_RDATA;
          else
            st_r <= ST_CMD;
        end
        ST_RDATA:
        begin
          bit_r <= bit_r + 4'h1;
          if (bit_r == 4'h7)
            st_r <= ST_RACK;
        end
        ST_RACK:
        begin
          bit_r <= 4'h0;
          // master ack fetches the low byte, nack ends the read
          st_r  <= sda_s ? ST_IGNORE : ST_RDATA;                      // [R12]
        end
        default: st_r <= st_r;
      endcase
    end
  end

  // command handling, driver select, conversion and result shift
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sel_r        <= SEL_X;
      drv_on_r     <= 1'b0;
      conv_pend_r  <= 1'b0;
      conv_start_o <= 1'b0;
      tx_r         <= 16'h0000;
    end
    else
    begin
      conv_start_o <= 1'b0;
      if (st_r == ST_CMD && bit_r == 4'h8 && scl_fall)
      begin
        // one layer on; a new coordinate turns the previous one off
        sel_r    <= cmd_sel;                                          // [R5] [R7]
        drv_on_r <= 1'b1;
      end
      // conversion starts as the read address is taken, so the word is loaded before
      // the first data bit has to appear on the line
      if (rd_go)
      begin
        conv_start_o <= 1'b1;                                         // [R6]
        conv_pend_r  <= 1'b1;
      end
      if (conv_pend_r && conv_done_i)
      begin
        tx_r        <= tx_load;                                       // [R6]
        conv_pend_r <= 1'b0;
      end
      else if (st_r == ST_RDATA && scl_fall)
        tx_r <= {tx_r[14:0], 1'b0};
      // stop ends the frame: driver on-time is bounded by bus clock pace
      if (stop_ev || (!pen_s && st_r == ST_IDLE))
        drv_on_r <= 1'b0;                                             // [R13] [R10]
    end
  end

  // layer drivers straight from flops; all off when idle
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      {x_drv_o, y_drv_o, z_drv_o} <= DRV_RESET;
    else
    begin
      x_drv_o <= drv_on_r & (sel_r == SEL_X);                         // [R1] [R5]
      y_drv_o <= drv_on_r & (sel_r == SEL_Y);                         // [R7]
      z_drv_o <= drv_on_r & ((sel_r == SEL_Z1) | (sel_r == SEL_Z2));
    end
  end

  // sda drive: ack low or data bit; released otherwise
  wire drive_ack = (st_r == ST_ACK);
  wire drive_dat = (st_r == ST_RDATA) & ~tx_r[15];
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sda_o    <= 1'b1;
      sda_oe_o <= 1'b0;
    end
    else
    begin
      sda_o    <= 1'b0;
      sda_oe_o <= talk_ok & (drive_ack | drive_dat);                  // [R1] [R6]
    end
  end

  // ---- checks ----
  x_y_excl_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !(x_drv_o && y_drv_o)) else $error("x and y drivers both on");   // [R7]
  idle_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (st_r == ST_IDLE && !drv_on_r) |=> !sda_oe_o) else $error("bus driven while idle"); // [R1]
  irq_pen_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (pen_s && !drv_on_r) |=> !pen_touch_irq_n) else $error("irq missing");  // [R2]
  irq_release_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !pen_s && !drv_on_r |=> pen_touch_irq_n) else $error("irq stuck");      // [R2]
  x_cmd_drv_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (drv_on_r && sel_r == SEL_X) |=> x_drv_o) else $error("x driver off");  // [R5]
  y_cmd_drv_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (drv_on_r && sel_r == SEL_Y) |=> (y_drv_o && !x_drv_o)) else $error("y driver"); // [R7]
  stop_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    stop_ev |=> ##1 !(x_drv_o || y_drv_o || z_drv_o)) else $error("driver on after stop"); // [R13]
  no_talk_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (start_ev && !talk_ok) |=> st_r == ST_IGNORE) else $error("answered without pen"); // [R15]
  conv_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // [R6]
    (conv_pend_r && conv_done_i) |=> (tx_r == $past(tx_load))) else $error("result not loaded");
  cv_x: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) $rose(x_drv_o));
  cv_y: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    $fell(x_drv_o) ##[1:400] y_drv_o);
  cv_irq: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) $fell(pen_touch_irq_n));
endmodule

/* File: command_touch_readout_tb_top.sv */
`timescale 1ns/1ps
// bench: host model on the bus, panel and converter driven here
module command_touch_readout_tb_top;
  import touch_pkg::*;
  // stimulus
  logic        sys_clk_i   = 1'b0;
  logic        rst_b_i     = 1'b0;
  logic        pen_down_i  = 1'b0;
  logic        conv_done_i = 1'b0;
  logic [11:0] conv_data_i = 12'h000;
  // design outputs
  logic        x_drv_o;
  logic        y_drv_o;
  logic        z_drv_o;
  logic        conv_start_o;
  logic        pen_touch_irq_n;
  logic        sda_o;
  logic        sda_oe_o;
  // bus lines; pulled up, so a released line reads high
  logic        scl;
  logic        host_low;
  wire  logic  sda_w = !(host_low || (sda_oe_o && !sda_o));
  // bookkeeping
  int          failures = 0;
  int          compares = 0;
  int          conv_cnt = 0;
  int          on_cnt   = 0;
  logic [2:0]  drv_seen = 3'h0;
  logic [2:0]  acks;
  logic [15:0] word;
  logic [2:0]  exp_drv [4] = '{3'h4, 3'h2, 3'h1, 3'h1};
  logic [1:0]  sel_tab [4] = '{SEL_X, SEL_Y, SEL_Z1, SEL_Z2};

  always #12.5 sys_clk_i = ~sys_clk_i;

  command_touch_readout DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .pen_down_i(pen_down_i), .x_drv_o(x_drv_o), .y_drv_o(y_drv_o), .z_drv_o(z_drv_o),
    .conv_start_o(conv_start_o), .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
    .pen_touch_irq_n(pen_touch_irq_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o));
  i2c_host_model host (.sys_clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl),
    .sda_low_o(host_low));

  // converter answers a cycle after start; drivers noted at each conversion
  always @(posedge sys_clk_i)
  begin
    conv_done_i <= conv_start_o;
    conv_cnt    <= conv_cnt + int'(conv_start_o);
    on_cnt      <= on_cnt + int'(x_drv_o | y_drv_o | z_drv_o);
    if (conv_start_o)
      drv_seen <= {x_drv_o, y_drv_o, z_drv_o};
  end

  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test;
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // bounded wait for the interrupt level
  task automatic wait_irq(input logic e);
    for (int i = 0; i < 20 && pen_touch_irq_n !== e; i++)
      @(posedge sys_clk_i);
  endtask

  // untouched panel: quiet drivers, no answer, no conversion
  task automatic t_idle;
    check("irq_idle", pen_touch_irq_n, 1'b1);
    check("drv_idle", {x_drv_o, y_drv_o, z_drv_o}, 3'h0);
    host.coord_read({SEL_X, 6'h00}, acks, word);
    check("ack_nopen", acks, 3'h0);
    check("conv_nopen", conv_cnt, 0);
  endtask
  // pressure raises the interrupt
  task automatic t_press;
    @(posedge sys_clk_i) pen_down_i <= 1'b1;
    wait_irq(1'b0);
    check("irq_press", pen_touch_irq_n, 1'b0);
  endtask
  // a full set of four reads, each coordinate in turn
  task automatic t_coords;
    logic [11:0] v;
    for (int s = 0; s < 4; s++)
    begin
      v = 12'h9c5 + 12'(s * 273);
      @(posedge sys_clk_i) conv_data_i <= v;
      host.coord_read({sel_tab[s], 6'h00}, acks, word);
      check("acks", acks, 3'h7);
      check("word", word, {v, 4'h0});
      check("convs", conv_cnt, s + 1);
      check("clocks", host.scl_cnt, FRAME_CLOCKS);
      check("drivers", drv_seen, exp_drv[s]);
      wait_irq(1'b0); // host unmasks and looks for pressure again
      check("irq_again", pen_touch_irq_n, 1'b0);
    end
  endtask
  // a foreign address is left unanswered
  task automatic t_bad;
    logic [7:0] tmp;
    logic       ack;
    host.start();
    host.xfer({~DEV_ADDR, 1'b0}, 1'b1, tmp, ack);
    host.stop();
    check("ack_bad", ack, 1'b0);
  endtask
  // a slower serial clock keeps the layer driven longer
  task automatic t_rate;
    int n0;
    int fast;
    n0 = on_cnt;
    host.coord_read({SEL_X, 6'h00}, acks, word);
    fast = on_cnt - n0;
    host.half_cyc = 8;
    n0 = on_cnt;
    host.coord_read({SEL_X, 6'h00}, acks, word);
    host.half_cyc = 4;
    check("slow_longer", (on_cnt - n0) > fast, 1'b1);
  endtask
  // pressure gone: interrupt released, drivers off
  task automatic t_release;
    @(posedge sys_clk_i) pen_down_i <= 1'b0;
    wait_irq(1'b1);
    check("irq_rel", pen_touch_irq_n, 1'b1);
    check("drv_rel", {x_drv_o, y_drv_o, z_drv_o}, 3'h0);
  endtask

  initial
  begin
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    t_idle();
    t_press();
    t_coords();
    t_bad();
    t_rate();
    t_release();
    stop_test();
  end
  // watchdog: the run needs well under 30000 cycles
  initial
  begin
    repeat (30000) @(posedge sys_clk_i);
    failures++;
    stop_test();
  end
endmodule

/* File: i2c_host_model.sv */
`timescale 1ns/1ps
// host processor on the serial bus: master drives the clock itself, data line open-drain and pulled up
module i2c_host_model
  import touch_pkg::*;
(
  // clock
  input  wire logic sys_clk_i,
  // resolved data line
  input  wire logic sda_i,
  // lines the host drives
  output logic      scl_o,
  output logic      sda_low_o
);
  int half_cyc = 4; // system clocks per serial half period; low runs one longer, high one shorter
  int scl_cnt  = 0; // serial clocks since the frame began
  initial
  begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end
  // one serial half period
  task automatic hp;
    repeat (half_cyc) @(posedge sys_clk_i);
  endtask
  // start or repeated start: data falls while the clock is high
  task automatic start;
    @(posedge sys_clk_i) sda_low_o <= 1'b0;
    hp();
    scl_o <= 1'b1;
    hp();
    sda_low_o <= 1'b1;
    hp();
    scl_o <= 1'b0;
    hp();
  endtask
  // stop: data rises while the clock is high, the clock then stays high
  task automatic stop;
    @(posedge sys_clk_i) sda_low_o <= 1'b1;
    hp();
    scl_o <= 1'b1;
    hp();
    sda_low_o <= 1'b0;
    hp();
  endtask
  // one bit; data moves a clock after scl falls so it never looks like a start
  task automatic bit_io(input logic b, output logic got);
    @(posedge sys_clk_i) sda_low_o <= !b;
    hp();
    scl_o <= 1'b1;
    scl_cnt++;
    repeat (half_cyc - 1) @(posedge sys_clk_i);
    got = sda_i;
    scl_o <= 1'b0;
  endtask
  // one byte plus its ninth bit; last=1 releases the line for the slave ack
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] got,
                      output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], g);
      got[i] = g;
    end
    bit_io(last, g);
    ack = !g;
  endtask
  // a coordinate read: write command, repeated start, two bytes back, stop
  task automatic coord_read(input logic [7:0] cmd, output logic [2:0] acks,
                            output logic [15:0] word);
    logic [7:0] tmp;
    scl_cnt = 0;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, tmp, acks[2]);
    xfer(cmd, 1'b1, tmp, acks[1]);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, tmp, acks[0]);
    xfer(8'hff, 1'b0, word[15:8], tmp[0]);
    xfer(8'hff, 1'b1, word[7:0], tmp[0]);
    stop();
  endtask
endmodule

/* File: sync_2ff.sv */
`timescale 1ns/1ps
// two-flop level synchroniser for one pin
module sync_2ff
#(
  parameter logic RST_VAL = 1'b1  // level held through reset, the pin's idle level
)
(
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  // pin in, synchronised level out
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_r;  // first stage, read only by second stage

  // two stages; reset value matches the pin's idle level so no false edge follows reset
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_r <= RST_VAL;
      sync_o <= RST_VAL;
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

/* File: touch_pkg.sv */
// Functional notes
// R1 - idle: drivers off, bus silent
// R2 - pressure asserts active-low touch interrupt
// R3 - host masks interrupt before service
// R4 - host command names one coordinate
// R5 - x command energises x layer driver
// R6 - convert sample, return word serially
// R7 - y after x: x off, y on
// R8 - host repeats command per sample
// R9 - host unmasks, rechecks pressure, repeats
// R10 - pressure gone: device returns idle
// R11 - i2c read frame is 45 clocks
// R12 - 12-bit read needs 48/49 clocks
// R13 - driver-on time follows serial clock
// R14 - full set needs four reads
// R15 - slave only, talks after pressure
package touch_pkg;
  // serial bus address and result width
  localparam logic [6:0] DEV_ADDR      = 7'h48;
  localparam int         RESULT_BITS   = 12;
  // command byte: bits 7:6 select the coordinate
  localparam int         CMD_SEL_HI    = 7;
  localparam int         CMD_SEL_LO    = 6;
  localparam logic [1:0] SEL_X         = 2'h0;
  localparam logic [1:0] SEL_Y         = 2'h1;
  localparam logic [1:0] SEL_Z1        = 2'h2;
  localparam logic [1:0] SEL_Z2        = 2'h3;
  // clocks of the serial bus per read frame
  localparam int         FRAME_CLOCKS  = 45;
  localparam int         READ_CLK_RS   = 48;
  localparam int         READ_CLK_SS   = 49;
  // synchroniser depth and layer driver reset value
  localparam int         SYNC_STAGES   = 2;
  localparam logic [2:0] DRV_RESET     = 3'h0;
endpackage
